//--- rtl/scp_pkg.sv
// Constants, types and helpers for the serial configuration port
package scp_pkg;
  // ==========================================================
  // Address map
  localparam logic [9:0] ADDR_CFG    = 10'h000;
  localparam logic [9:0] ADDR_RDSEL  = 10'h004;
  localparam logic [9:0] ADDR_UPDATE = 10'h232;
  localparam int         REG_COUNT   = int'(ADDR_UPDATE) + 1;

  // ==========================================================
  // Port configuration bits, low nibble mirrored in high nibble
  localparam int CFG_SEL_LO  = 0;
  localparam int CFG_SEL_HI  = 7;
  localparam int CFG_LSB_LO  = 1;
  localparam int CFG_LSB_HI  = 6;
  localparam int CFG_SRST_LO = 2;
  localparam int CFG_SRST_HI = 5;
  localparam int RDSEL_BIT   = 0;
  localparam int UPDATE_BIT  = 0;

  // ==========================================================
  // Reset values and frame counts
  localparam logic [7:0] CFG_RESET  = 8'h18;
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] BYTE_LAST  = 5'h07;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  // ==========================================================
  // Types
  typedef struct packed {
    logic        rdNotWr;
    logic [1:0]  lengthCode;
    logic [12:0] startAddrField;
  } scp_instr_t;

  typedef struct packed {
    logic uniDir;
    logic lsbFirst;
    logic softRst;
  } scp_cfg_t;

  typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_DONE} scp_state_t;

  // Next address: up when LSB first, down and wrapping to the top otherwise
  function automatic logic [9:0] scp_step_addr(input logic [9:0] a, input logic lsb);
    logic [9:0] n;
    if (lsb) begin
      n = a + 10'h001;
    end else if (a == ADDR_CFG) begin
      n = ADDR_UPDATE;
    end else begin
      n = a - 10'h001;
    end
    return n;
  endfunction

  // Mirrored readback of the port configuration byte
  function automatic logic [7:0] scp_cfg_byte(input scp_cfg_t c);
    logic [7:0] b;
    b = CFG_RESET;
    b[CFG_SEL_LO]  = c.uniDir;
    b[CFG_SEL_HI]  = c.uniDir;
    b[CFG_LSB_LO]  = c.lsbFirst;
    b[CFG_LSB_HI]  = c.lsbFirst;
    b[CFG_SRST_LO] = c.softRst;
    b[CFG_SRST_HI] = c.softRst;
    return b;
  endfunction
endpackage

//--- rtl/scp_serial_port.sv
// Serial configuration port with buffered and active register banks
`timescale 1ns/1ns

module scp_serial_port
  import scp_pkg::*;
(
  // System clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Serial link
  input  wire logic       sclk,
  input  wire logic       chipSelN,
  input  wire logic       dataLineIn,
  output logic            dataLineOut,
  output logic            dataLineOe,
  output logic            readbackOutLine,
  output logic            readbackOutLineOe,
  // Power control
  input  wire logic       powerDownPinN,
  // Core view of the running settings
  input  wire logic [9:0] coreAddr,
  output logic      [7:0] coreData,
  output logic            softResetActive,
  output logic            powerDownActive
);

  // ==========================================================
  // Declarations
  logic       linkRstMeta_r;
  logic       linkRst_r;
  logic       csHigh_r;
  scp_state_t state_r;
  logic [4:0] bitCnt_r;
  logic [15:0] shift_r;
  scp_instr_t instr_r;
  logic [9:0] curAddr_r;
  logic [1:0] bytesLeft_r;
  logic [7:0] rdShift_r;
  scp_cfg_t   cfg_r;
  logic       updTgl_r;
  logic [7:0] bufBank_r [0:REG_COUNT-1];
  logic [7:0] actBank_r [0:REG_COUNT-1];
  logic       outBit_r;
  logic       dataOe_r;
  logic       rbOe_r;
  // System domain
  logic       pdMeta_r;
  logic       pdSync_r;
  logic       pdActive_r;
  logic       srstMeta_r;
  logic       srstSync_r;
  logic       updMeta_r;
  logic       updSync_r;
  logic       updSeen_r;
  logic       pending_r;
  logic [7:0] runBank_r [0:REG_COUNT-1];
  logic [7:0] coreData_r;
  // Combinational
  logic       active;
  logic       restart;
  logic       inInstr;
  logic [4:0] curCnt;
  logic [15:0] shiftIn;
  scp_instr_t instrWord;
  logic [7:0] dataByte;
  logic       instrDone;
  logic       byteDone;
  logic       isStream;
  logic       lastByte;
  logic       wrEn;
  logic       cfgWr;
  logic       updWr;
  logic       rdSelAct;
  logic [9:0] nextAddr;
  logic [9:0] rdAddr;
  logic [7:0] rdByte;
  logic       updEvent;
  logic       copyNow;

  // ==========================================================
  // Link side
  // Reset carried into the link clock
  always_ff @(posedge sclk) begin
    linkRstMeta_r <= reset;
    linkRst_r     <= linkRstMeta_r;
  end

  // Remembers any select-high interval since the last edge
  always_ff @(posedge sclk or posedge chipSelN) begin
    if (chipSelN) begin
      csHigh_r <= 1'b1;
    end else begin
      csHigh_r <= 1'b0;
    end
  end

  // Frame decode
  always_comb begin
    active = !chipSelN;
    restart = csHigh_r && ((bitCnt_r[2:0] != 3'h0) || (state_r == ST_DONE)
              || (state_r == ST_DATA && instr_r.lengthCode == LEN_STREAM));
    inInstr = restart || (state_r == ST_INSTR);
    curCnt  = restart ? 5'h00 : bitCnt_r;
    shiftIn  = cfg_r.lsbFirst ? {dataLineIn, shift_r[15:1]} : {shift_r[14:0], dataLineIn};
    dataByte = cfg_r.lsbFirst ? {dataLineIn, shift_r[7:1]} : {shift_r[6:0], dataLineIn};
    instrWord = scp_instr_t'(shiftIn);
    instrDone = active && inInstr && (curCnt == INSTR_LAST);
    byteDone  = active && !inInstr && (state_r == ST_DATA) && (bitCnt_r == BYTE_LAST);
    isStream  = (instr_r.lengthCode == LEN_STREAM);
    lastByte  = (curAddr_r == ADDR_UPDATE) || (!isStream && bytesLeft_r == 2'h0);
    wrEn      = byteDone && !instr_r.rdNotWr;
    cfgWr     = wrEn && (curAddr_r == ADDR_CFG);
    updWr     = wrEn && (curAddr_r == ADDR_UPDATE) && dataByte[UPDATE_BIT] && !cfg_r.softRst;
    nextAddr  = scp_step_addr(curAddr_r, cfg_r.lsbFirst);
    rdAddr    = instrDone ? instrWord.startAddrField[9:0] : nextAddr;
    rdSelAct  = bufBank_r[ADDR_RDSEL][RDSEL_BIT];
    // unmapped and update reads give zero
    if (rdAddr == ADDR_CFG) begin
      rdByte = scp_cfg_byte(cfg_r);
    end else if (rdAddr >= ADDR_UPDATE) begin
      rdByte = '0;
    end else begin
      rdByte = rdSelAct ? actBank_r[rdAddr] : bufBank_r[rdAddr];
    end
  end

  // Instruction and data sequencer
  always_ff @(posedge sclk) begin
    if (linkRst_r) begin
      state_r     <= ST_INSTR;
      bitCnt_r    <= '0;
      shift_r     <= '0;
      instr_r     <= '0;
      curAddr_r   <= ADDR_CFG;
      bytesLeft_r <= '0;
    end else if (active) begin
      if (inInstr) begin
        shift_r <= shiftIn;
        if (curCnt == INSTR_LAST) begin
          instr_r     <= instrWord;
          curAddr_r   <= instrWord.startAddrField[9:0];
          bytesLeft_r <= instrWord.lengthCode;
          state_r     <= ST_DATA;
          bitCnt_r    <= '0;
        end else begin
          state_r  <= ST_INSTR;
          bitCnt_r <= curCnt + 5'h01;
        end
      end else if (state_r == ST_DATA) begin
        shift_r[7:0] <= dataByte;
        if (byteDone) begin
          bitCnt_r    <= '0;
          curAddr_r   <= nextAddr;
          bytesLeft_r <= bytesLeft_r - 2'h1;
          if (lastByte) begin
            state_r <= (!isStream && bytesLeft_r == 2'h0) ? ST_INSTR : ST_DONE;
          end
        end else begin
          bitCnt_r <= bitCnt_r + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge sclk) begin
    if (linkRst_r) begin
      rdShift_r <= '0;
    end else if (active) begin
      if (instrDone || (byteDone && !lastByte)) begin
        rdShift_r <= rdByte;
      end else begin
        rdShift_r <= cfg_r.lsbFirst ? {1'b0, rdShift_r[7:1]} : {rdShift_r[6:0], 1'b0};
      end
    end
  end

  // Port configuration, effective at once
  always_ff @(posedge sclk) begin
    if (linkRst_r) begin
      cfg_r <= '0;
    end else if (cfgWr) begin
      // both bits set starts soft reset
      if (dataByte[CFG_SRST_LO] && dataByte[CFG_SRST_HI]) begin
        cfg_r <= '{uniDir: 1'b0, lsbFirst: 1'b0, softRst: 1'b1};
      end else if (!dataByte[CFG_SRST_LO] && !dataByte[CFG_SRST_HI]) begin
        cfg_r.softRst  <= 1'b0;
        cfg_r.uniDir   <= dataByte[CFG_SEL_LO] || dataByte[CFG_SEL_HI];
        cfg_r.lsbFirst <= dataByte[CFG_LSB_LO] || dataByte[CFG_LSB_HI];
      end
    end
  end

  // Buffer and active banks
  always_ff @(posedge sclk) begin
    if (linkRst_r || cfg_r.softRst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        bufBank_r[i] <= REG_RESET;
        actBank_r[i] <= REG_RESET;
      end
    end else begin
      if (wrEn && curAddr_r != ADDR_CFG && curAddr_r < ADDR_UPDATE) begin
        bufBank_r[curAddr_r] <= dataByte;
      end
      if (updWr) begin
        for (int i = 0; i < REG_COUNT; i++) begin
          actBank_r[i] <= bufBank_r[i];
        end
      end
    end
  end

  // Update event toggle for the system side
  always_ff @(posedge sclk) begin
    if (linkRst_r) begin
      updTgl_r <= 1'b0;
    end else if (updWr) begin
      updTgl_r <= !updTgl_r;
    end
  end

  always_ff @(negedge sclk or posedge chipSelN) begin
    if (chipSelN) begin
      outBit_r <= 1'b0;
      dataOe_r <= 1'b0;
      rbOe_r   <= 1'b0;
    end else if (linkRst_r) begin
      outBit_r <= 1'b0;
      dataOe_r <= 1'b0;
      rbOe_r   <= 1'b0;
    end else begin
      outBit_r <= cfg_r.lsbFirst ? rdShift_r[0] : rdShift_r[7];
      // zeros keep flowing after the stop
      dataOe_r <= (state_r != ST_INSTR) && instr_r.rdNotWr && !cfg_r.uniDir;
      rbOe_r   <= (state_r != ST_INSTR) && instr_r.rdNotWr && cfg_r.uniDir;
    end
  end

  assign dataLineOut       = outBit_r;
  assign dataLineOe        = dataOe_r;
  assign readbackOutLine   = outBit_r;
  assign readbackOutLineOe = rbOe_r;

  // ==========================================================
  // System side
  // Synchronisers for pin, soft reset and update toggle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pdMeta_r   <= 1'b1;
      pdSync_r   <= 1'b1;
      srstMeta_r <= 1'b0;
      srstSync_r <= 1'b0;
      updMeta_r  <= 1'b0;
      updSync_r  <= 1'b0;
      updSeen_r  <= 1'b0;
    end else begin
      pdMeta_r   <= powerDownPinN;
      pdSync_r   <= pdMeta_r;
      srstMeta_r <= cfg_r.softRst;
      srstSync_r <= srstMeta_r;
      updMeta_r  <= updTgl_r;
      updSync_r  <= updMeta_r;
      updSeen_r  <= updSync_r;
    end
  end

  assign updEvent = updSync_r ^ updSeen_r;
  assign copyNow  = pending_r && pdSync_r && !srstSync_r;

  // Pending update, a new event wins over the clear by a copy
  always_ff @(posedge sys_clk) begin
    if (reset || srstSync_r) begin
      pending_r <= 1'b0;
    end else begin
      pending_r <= (pending_r && !copyNow) || updEvent;
    end
  end

  // running copy taken at wake-up or update
  always_ff @(posedge sys_clk) begin
    if (reset || srstSync_r) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        runBank_r[i] <= REG_RESET;
      end
    end else if (copyNow) begin
      // Active bank is quiet between updates
      for (int i = 0; i < REG_COUNT; i++) begin
        runBank_r[i] <= actBank_r[i];
      end
    end
  end

  // Core read port and status flags
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      coreData_r <= '0;
      pdActive_r <= 1'b0;
    end else begin
      coreData_r <= (coreAddr < ADDR_UPDATE) ? runBank_r[coreAddr] : '0;
      pdActive_r <= !pdSync_r;
    end
  end

  assign coreData        = coreData_r;
  assign softResetActive = srstSync_r;
  assign powerDownActive = pdActive_r;

  // ==========================================================
  // Assertions
  sequence partialGap_s;
    active && csHigh_r && (bitCnt_r[2:0] != 3'h0);
  endsequence
  sequence shortStall_s;
    active && csHigh_r && (bitCnt_r == 5'h00) && (state_r == ST_DATA) && !isStream;
  endsequence
  sequence wakeCopy_s;
    pending_r && pdSync_r && !srstSync_r;
  endsequence

  csHighZ_a: assert property (
    @(posedge sclk) chipSelN |-> !dataOe_r && !rbOe_r)
    else $error("Output enabled while select high");
  srstSet_a: assert property (
    @(posedge sclk) disable iff (linkRst_r)
    cfgWr && dataByte[CFG_SRST_LO] && dataByte[CFG_SRST_HI]
    |=> cfg_r.softRst ##1 (actBank_r[ADDR_RDSEL] == REG_RESET))
    else $error("Soft reset did not take effect");
  srstHold_a: assert property (
    @(posedge sclk) disable iff (linkRst_r)
    cfg_r.softRst && !(cfgWr && !dataByte[CFG_SRST_LO] && !dataByte[CFG_SRST_HI])
    |=> cfg_r.softRst)
    else $error("Soft reset cleared itself");
  readDrive_a: assert property (
    @(posedge sclk) (dataOe_r || rbOe_r)
    |-> instr_r.rdNotWr && (state_r != ST_INSTR) && (rbOe_r == cfg_r.uniDir)
    && !(dataOe_r && rbOe_r))
    else $error("Readback driven on wrong line or phase");
  gapFlush_a: assert property (
    @(posedge sclk) disable iff (linkRst_r)
    partialGap_s |=> (state_r == ST_INSTR) && (bitCnt_r == 5'h01))
    else $error("Partial byte gap not flushed");
  stallKeep_a: assert property (
    @(posedge sclk) disable iff (linkRst_r)
    shortStall_s |=> (state_r == ST_DATA) && (bitCnt_r == 5'h01))
    else $error("Stalled transfer lost its place");
  instrEnd_a: assert property (
    @(posedge sclk) disable iff (linkRst_r)
    instrDone |=> (state_r == ST_DATA) && (bitCnt_r == 5'h00)
    && (curAddr_r == $past(instrWord.startAddrField[9:0])))
    else $error("Instruction not decoded after sixteen bits");
  addrStep_a: assert property (
    @(posedge sclk) disable iff (linkRst_r)
    byteDone && !lastByte && !cfg_r.lsbFirst && (curAddr_r != ADDR_CFG)
    |=> curAddr_r == $past(curAddr_r) - 10'h001)
    else $error("Address did not step down");
  streamStop_a: assert property (
    @(posedge sclk) disable iff (linkRst_r)
    byteDone && isStream && (curAddr_r == ADDR_UPDATE) |=> state_r == ST_DONE)
    else $error("Streaming ran past the update location");
  updCopy_a: assert property (
    @(posedge sclk) disable iff (linkRst_r)
    updWr |=> (actBank_r[ADDR_RDSEL] == $past(bufBank_r[ADDR_RDSEL]))
    && (updTgl_r != $past(updTgl_r)))
    else $error("Update did not copy buffer");
  rdLoad_a: assert property (
    @(posedge sclk) disable iff (linkRst_r)
    instrDone && instrWord.rdNotWr |=> rdShift_r == $past(rdByte))
    else $error("Read byte not loaded");
  pdFreeze_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    !pdSync_r && !srstSync_r |=> runBank_r[ADDR_RDSEL] == $past(runBank_r[ADDR_RDSEL]))
    else $error("Settings changed during power-down");
  wakeApply_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    wakeCopy_s |=> runBank_r[ADDR_RDSEL] == $past(actBank_r[ADDR_RDSEL]))
    else $error("Pending settings not applied");
endmodule

//--- test/scp_host_model.sv
// Behavioural host that drives the serial link of the port
`timescale 1ns/1ns
module scp_host_model (
  // Link drive
  output logic      sclk,
  output logic      chipSelN,
  output logic      hostDrv,
  // Resolved lines and device enables
  input  wire logic dioWire,
  input  wire logic readback_out_line,
  input  wire logic dioOe,
  input  wire logic sdoOe
);
  logic [7:0] txQ[$];
  logic [7:0] rxQ[$];
  int         oeBad;

  // ==========================================================
  // Idle link: clock still, select high
  initial begin
    sclk = 1'b0;
    chipSelN = 1'b1;
    hostDrv = 1'b0;
    oeBad = 0;
  end

  // Clock pulses with select high, for link reset
  task automatic idle(input int n);
    repeat (n) begin
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
  endtask

  // ==========================================================
  // select low, instruction then data bits
  task automatic frame(input logic [15:0] ins, input int nb, input int stl,
                       input bit lf, input bit uf);
    logic [7:0] by;
    int         b;
    rxQ.delete();
    #7 chipSelN = 1'b0;
    for (int k = 0; k < nb; k++) begin
      // select high only on a byte boundary
      if (k == stl) begin
        chipSelN = 1'b1;
        #150 chipSelN = 1'b0;
      end
      b = lf ? k % 8 : 7 - k % 8;
      if (k < 16) hostDrv = lf ? ins[k] : ins[15-k];
      else if (!ins[15]) hostDrv = txQ[(k-16)/8][b];
      else hostDrv = ~hostDrv;  // Released line toggles
      #32 sclk = 1'b1;
      if (ins[15] && k >= 16) begin
        by[b] = uf ? readback_out_line : dioWire;
        if (uf ? (!sdoOe || dioOe) : !dioOe) oeBad++;
        if (k % 8 == 7) rxQ.push_back(by);
      end else if (dioOe || sdoOe) oeBad++;
      #32 sclk = 1'b0;
    end
    #32 chipSelN = 1'b1;
    hostDrv = ~hostDrv;
  endtask
endmodule

//--- test/scp_serial_port_tb.sv
// Self-checking bench for the serial configuration port
`timescale 1ns/1ns
module scp_serial_port_tb
  import scp_pkg::*;
;
  logic       sys_clk;
  logic       reset;
  logic       sclk;
  logic       chipSelN;
  logic       hostDrv;
  logic       dataLineIn;
  logic       dataLineOut;
  logic       dataLineOe;
  logic       readbackOutLine;
  logic       readbackOutLineOe;
  logic       sdoWire;
  logic       powerDownPinN;
  logic [9:0] coreAddr;
  logic [7:0] coreData;
  logic       softResetActive;
  logic       powerDownActive;
  int         num_errors;
  int         checks;
  int         ta;
  int         bk[0:562];
  int         ak[0:562];
  int         rk[0:562];
  bit         uni;
  bit         lsb;
  bit         srst;
  bit         pdOn;

  // Wire levels: device drive or host pattern
  assign dataLineIn = dataLineOe ? dataLineOut : hostDrv;
  assign sdoWire = readbackOutLineOe ? readbackOutLine : hostDrv;

  scp_serial_port u_dut (
    .sys_clk           (sys_clk),
    .reset             (reset),
    .sclk              (sclk),
    .chipSelN          (chipSelN),
    .dataLineIn        (dataLineIn),
    .dataLineOut       (dataLineOut),
    .dataLineOe        (dataLineOe),
    .readbackOutLine   (readbackOutLine),
    .readbackOutLineOe (readbackOutLineOe),
    .powerDownPinN     (powerDownPinN),
    .coreAddr          (coreAddr),
    .coreData          (coreData),
    .softResetActive   (softResetActive),
    .powerDownActive   (powerDownActive)
  );

  scp_host_model u_host (
    .sclk     (sclk),
    .chipSelN (chipSelN),
    .hostDrv  (hostDrv),
    .dioWire  (dataLineIn),
    .readback_out_line      (sdoWire),
    .dioOe    (dataLineOe),
    .sdoOe    (readbackOutLineOe)
  );

  // System clock, 20 ns
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Compare and closing tasks
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // Reference model of both banks and the running copy
  function automatic int step(input int a);
    return lsb ? a + 1 : (a == 0 ? int'(ADDR_UPDATE) : a - 1);
  endfunction

  function automatic logic [7:0] mrd(input int a);
    if (a == 0) return {uni, lsb, srst, 2'b11, srst, lsb, uni};
    if (a >= ADDR_UPDATE) return 8'h00;
    return bk[4][0] ? 8'(ak[a]) : 8'(bk[a]);
  endfunction

  task automatic clr();
    bk = '{default: 0};
    ak = '{default: 0};
    rk = '{default: 0};
  endtask

  task automatic mwr(input int a, input logic [7:0] d);
    if (a == 0) begin
      if (d[2] && d[5]) begin
        srst = 1'b1;
        uni = 1'b0;
        lsb = 1'b0;
        clr();
      end else if (!d[2] && !d[5]) begin
        srst = 1'b0;
        uni = d[0] | d[7];
        lsb = d[1] | d[6];
      end
    end else if (!srst && a == ADDR_UPDATE && d[0]) begin
      ak = bk;
      if (!pdOn) rk = ak;
    end else if (!srst && a < ADDR_UPDATE) bk[a] = d;
  endtask

  // One frame; model checks reads and applies whole written bytes
  task automatic xfer(input bit rd, input int ln, input int a, input int n,
                      input int stl = -1, input int cut = 0, input int d = -1);
    int nb;
    u_host.txQ.delete();
    repeat (n) u_host.txQ.push_back(d < 0 ? 8'($urandom) : 8'(d));
    nb = cut ? cut : 16 + 8 * n;
    u_host.frame({rd, 2'(ln), 3'h0, 10'(a)}, nb, stl, lsb, uni);
    for (int i = 0; i < n && 24 + 8 * i <= nb; i++) begin
      if (rd) cmp8(u_host.rxQ[i], a < 0 ? 8'h00 : mrd(a));
      else if (a >= 0) mwr(a, u_host.txQ[i]);
      a = (a == ADDR_UPDATE || a < 0) ? -1 : step(a);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic core_chk(input int a);
    @(negedge sys_clk) coreAddr = 10'(a);
    wt(2);
    cmp8(coreData, 8'(rk[a]));
  endtask

  // Deselected device must release both lines
  always @(negedge sys_clk) begin
    if (!reset && chipSelN === 1'b1 && (dataLineOe !== 1'b0 || readbackOutLineOe !== 1'b0)) begin
      num_errors++;
      $display("mismatch at %0t: line driven while deselected", $time);
    end
  end

  // Watchdog
  initial begin
    #1000000;
    num_errors++;
    $display("mismatch at %0t: run timed out", $time);
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    num_errors = 0;
    checks = 0;
    reset = 1'b1;
    powerDownPinN = 1'b1;
    coreAddr = 10'h000;
    clr();
    void'($urandom(36954));
    wt(2);
    u_host.idle(4);
    @(negedge sys_clk) reset = 1'b0;
    u_host.idle(4);
    xfer(1, 0, 0, 1);
    xfer(1, 0, 4, 1);
    core_chk(4);
    $display("test reset_defaults done");
    ta = 32'h0000_0010 + $urandom_range(0, 32'h0000_01F0);
    xfer(0, 2, ta, 3, 24);
    xfer(1, 2, ta, 3, 8);
    xfer(0, 0, ta, 1, -1, 20);
    xfer(1, 0, ta, 1);
    core_chk(ta);
    $display("test multibyte_stall_cut done");
    xfer(0, 0, ADDR_UPDATE, 1, -1, 0, 1);
    wt(10);
    for (int i = 0; i < 3; i++) core_chk(ta - i);
    xfer(0, 0, 4, 1, -1, 0, 1);
    xfer(0, 1, ta, 2);
    xfer(1, 2, ta, 3);
    xfer(0, 0, 4, 1, -1, 0, 0);
    xfer(1, 2, ta, 3);
    $display("test update_readback done");
    xfer(0, 0, 0, 1, -1, 0, 32'h0000_0042);
    xfer(0, 3, ADDR_UPDATE - 2, 4);
    xfer(1, 3, ADDR_UPDATE - 3, 6);
    xfer(0, 0, 0, 1, -1, 0, 0);
    xfer(1, 3, 2, 5);
    $display("test streaming done");
    xfer(0, 0, 0, 1, -1, 0, 32'h0000_0081);
    xfer(1, 1, ta, 2);
    xfer(0, 0, 0, 1, -1, 0, 0);
    $display("test unidirectional done");
    @(negedge sys_clk) powerDownPinN = 1'b0;
    pdOn = 1'b1;
    wt(5);
    cmp1(powerDownActive, 1'b1);
    xfer(0, 0, ta, 1);
    xfer(0, 0, ADDR_UPDATE, 1, -1, 0, 1);
    wt(10);
    core_chk(ta);
    @(negedge sys_clk) powerDownPinN = 1'b1;
    pdOn = 1'b0;
    rk = ak;
    wt(10);
    core_chk(ta);
    cmp1(powerDownActive, 1'b0);
    $display("test power_down done");
    xfer(0, 0, 0, 1, -1, 0, 32'h0000_0024);
    wt(5);
    cmp1(softResetActive, 1'b1);
    xfer(1, 0, 0, 1);
    xfer(0, 0, ta, 1, -1, 0, 32'h0000_0055);
    xfer(1, 0, ta, 1);
    core_chk(ta);
    xfer(0, 0, 0, 1, -1, 0, 0);
    wt(5);
    cmp1(softResetActive, 1'b0);
    xfer(1, 0, ta, 1);
    cmp1(u_host.oeBad == 0, 1'b1);
    $display("test soft_reset done");
    finish_test();
  end
endmodule
